// *** hdl/pcr_port_clock_reset_prbs_ctrl.sv ***
/*
 * Per-MAC clock select / soft reset / power-down registers and the
 * test-pattern control lanes, for four MACs behind one AHB-Lite slave.
 * Assumes strap pins are stable around reset release and all inputs
 * are synchronous to hclk.
 */
`timescale 1ns/1ps
module pcr_port_clock_reset_prbs_ctrl
    import pcr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] speed_strap_pin,
    input wire logic [7:0] port_power_down_pin,
    input wire logic [7:0] xcvr_power_down,
    output logic [7:0] clock_select,
    output logic [3:0] odd_port_soft_reset,
    output logic [3:0] even_port_transceiver_soft_reset,
    output logic [3:0] odd_port_powered_down,
    output logic [3:0] even_port_powered_down,
    output logic [47:0] tx_pattern_select,
    output logic [15:0] generator_run,
    output logic [15:0] checker_sync,
    output logic [15:0] counter_freeze,
    output logic [15:0] counter_clear,
    output logic [15:0] counter_enable
);
    localparam int B3 = 3 * LANE_W;

    logic wr_q;
    logic rd_q;
    logic [31:0] addr_q;
    logic [1:0] sel_mac;
    logic hit_clk;
    logic hit_pat;
    logic wr_clk;
    logic wr_pat;
    logic straps_taken;
    logic [31:0] next_hrdata;
    logic [31:0] clk_word [NUM_MACS];
    logic [31:0] pat_word [NUM_MACS];
    logic [7:0] lane_rd [NUM_CH];

    pcr_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hsize(hsize),
        .hwrite(hwrite),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_q(wr_q),
        .rd_q(rd_q),
        .addr_q(addr_q)
    );

    // decode: the two MAC-select address bits are masked before matching
    assign sel_mac = addr_q[MAC_SEL_LSB +: 2];
    assign hit_clk = (addr_q & ~MAC_STRIDE_BITS) == OFF_CLK_SEL;
    assign hit_pat = (addr_q & ~MAC_STRIDE_BITS) == OFF_PAT_CTRL;
    assign wr_clk = wr_q && hit_clk;
    assign wr_pat = wr_q && hit_pat;

    // straps are sampled at the first edge after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            straps_taken <= 1'b0;
        end else begin
            straps_taken <= 1'b1;
        end
    end

    // per-MAC clock select, soft reset and power-down register
    for (genvar m = 0; m < NUM_MACS; m++) begin : g_mac
        logic wsel;
        logic odd_rst;
        logic even_rst;
        logic odd_pd_bit;
        logic pair_pd_bit;
        logic odd_down;
        logic even_down;
        pcr_clk_src_t clk_sel;

        assign wsel = wr_clk && (sel_mac == 2'(m));

        // strap capture first, then software owns every field
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                odd_rst <= BIT_RESET;
                even_rst <= BIT_RESET;
                odd_pd_bit <= BIT_RESET;
                pair_pd_bit <= BIT_RESET;
                clk_sel <= pcr_clk_src_t'(CLK_SEL_RESET);
            end else if (!straps_taken) begin
                odd_pd_bit <= port_power_down_pin[2 * m + 1];
                pair_pd_bit <= port_power_down_pin[2 * m];
                clk_sel <= pcr_clk_src_t'(speed_strap_pin[2 * m +: 2]);
            end else if (wsel) begin
                odd_rst <= hwdata[BIT_ODD_RST];
                even_rst <= hwdata[BIT_EVEN_RST];
                odd_pd_bit <= hwdata[BIT_ODD_PD];
                pair_pd_bit <= hwdata[BIT_PAIR_PD];
                clk_sel <= pcr_clk_src_t'(hwdata[CLK_SEL_LSB +: 2]);
            end
        end

        // pair bit downs both ports, odd bit only the odd one
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                odd_down <= BIT_RESET;
                even_down <= BIT_RESET;
            end else begin
                odd_down <= odd_pd_bit | pair_pd_bit | xcvr_power_down[2 * m + 1];
                even_down <= pair_pd_bit | xcvr_power_down[2 * m];
            end
        end

        assign odd_port_soft_reset[m] = odd_rst;
        assign even_port_transceiver_soft_reset[m] = even_rst;
        assign odd_port_powered_down[m] = odd_down;
        assign even_port_powered_down[m] = even_down;
        assign clock_select[2 * m +: 2] = clk_sel;
        // unused upper bits read back as zero
        assign clk_word[m] = {(32 - CLK_USED_W)'(0), odd_rst, even_rst,
            odd_pd_bit, pair_pd_bit, clk_sel};
        assign pat_word[m] = {lane_rd[4 * m + 3], lane_rd[4 * m + 2], lane_rd[4 * m + 1], lane_rd[4 * m]};
    end

    // per-channel test-pattern lane; channel i sits in MAC i/4, lane i%4
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam int B = (i % LANES) * LANE_W;
        logic wsel;
        logic sync_start;
        logic next_freeze;
        logic [2:0] pat;
        logic run;
        logic freeze;
        logic clr;
        logic en;

        assign wsel = wr_pat && (sel_mac == 2'(i / LANES));
        assign sync_start = wsel && hwdata[B + LANE_SYNC];
        assign next_freeze = wsel ? hwdata[B + LANE_FREEZE] : freeze;

        // stored fields; clear is a one-cycle pulse that never reads back
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pat <= PAT_SEL_RESET;
                run <= BIT_RESET;
                freeze <= BIT_RESET;
                clr <= BIT_RESET;
            end else begin
                clr <= wsel && hwdata[B + LANE_CLEAR];
                if (wsel) begin
                    pat <= hwdata[B + LANE_SEL_LSB +: 3];
                    run <= hwdata[B + LANE_START];
                    freeze <= hwdata[B + LANE_FREEZE];
                end
            end
        end

        // counting stays off after unfreeze until a sync is issued
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                en <= BIT_RESET;
            end else if (next_freeze) begin
                en <= 1'b0;
            end else if (sync_start) begin
                en <= 1'b1;
            end
        end

        pcr_pulse_stretch u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .start(sync_start),
            .active(checker_sync[i])
        );

        assign tx_pattern_select[3 * i +: 3] = pat;
        assign generator_run[i] = run;
        assign counter_freeze[i] = freeze;
        assign counter_clear[i] = clr;
        assign counter_enable[i] = en;
        // sync and clear read as zero: they are self-clearing actions
        assign lane_rd[i] = {1'b0, pat, run, 1'b0, freeze, 1'b0};
    end

    // read mux; unmapped addresses return zero with an okay response
    always_comb begin
        next_hrdata = READ_UNMAPPED;
        if (hit_clk) begin
            next_hrdata = clk_word[sel_mac];
        end else if (hit_pat) begin
            next_hrdata = pat_word[sel_mac];
        end
    end

    // loaded in the wait cycle of a read data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= PAT_CTRL_RESET;
        end else if (rd_q) begin
            hrdata <= next_hrdata;
        end
    end

    // length of the running channel 3 sync pulse; a restart begins it again
    logic [2:0] sync_high_count;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_high_count <= 3'h0;
        end else if (g_ch[3].sync_start || !checker_sync[3]) begin
            sync_high_count <= 3'h0;
        end else if (sync_high_count != 3'h7) begin
            sync_high_count <= sync_high_count + 3'h1; // saturates so a stuck pulse keeps failing
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    strap_speed_a: assert property (straps_taken && !$past(straps_taken)
        |-> clock_select[1:0] == $past(speed_strap_pin[1:0]))
        else $error("clock select did not take the speed strap");
    strap_odd_pd_a: assert property (straps_taken && !$past(straps_taken)
        |-> g_mac[0].odd_pd_bit == $past(port_power_down_pin[1]))
        else $error("odd power-down bit did not take its pin");
    strap_pair_pd_a: assert property (straps_taken && !$past(straps_taken)
        |-> g_mac[0].pair_pd_bit == $past(port_power_down_pin[0]))
        else $error("pair power-down bit did not take its pin");
    strap_mac3_a: assert property (straps_taken && !$past(straps_taken)
        |-> clock_select[7:6] == $past(speed_strap_pin[7:6]))
        else $error("last MAC clock select did not take its strap");
    odd_reset_a: assert property (wr_clk && sel_mac == 2'h0
        |=> odd_port_soft_reset[0] == $past(hwdata[BIT_ODD_RST]))
        else $error("odd port reset not written");
    even_reset_a: assert property (wr_clk && sel_mac == 2'h3
        |=> even_port_transceiver_soft_reset[3] == $past(hwdata[BIT_EVEN_RST]))
        else $error("even port reset of last MAC not written");
    odd_pd_write_a: assert property (wr_clk && sel_mac == 2'h3
        |=> g_mac[3].odd_pd_bit == $past(hwdata[BIT_ODD_PD]))
        else $error("odd power-down write lost");
    pair_pd_write_a: assert property (wr_clk && sel_mac == 2'h2
        |=> g_mac[2].pair_pd_bit == $past(hwdata[BIT_PAIR_PD]))
        else $error("pair power-down write lost");
    speed_write_a: assert property (wr_clk && sel_mac == 2'h1 |=> clock_select[3:2] == $past(hwdata[1:0]))
        else $error("clock select write lost");
    power_or_a: assert property (straps_taken && $past(straps_taken)
        |-> odd_port_powered_down[0] == $past(g_mac[0].odd_pd_bit | g_mac[0].pair_pd_bit | xcvr_power_down[1]))
        else $error("odd port power-down is not the or of its sources");
    even_power_or_a: assert property (straps_taken && $past(straps_taken)
        |-> even_port_powered_down[2] == $past(g_mac[2].pair_pd_bit | xcvr_power_down[4]))
        else $error("even port power-down is not the or of its sources");
    reserved_zero_a: assert property (rd_q && hit_clk |=> hrdata[31:CLK_USED_W] == 26'h0)
        else $error("reserved clock-select bits read nonzero");
    pattern_sel_a: assert property (wr_pat && sel_mac == 2'h0
        |=> tx_pattern_select[11:9] == $past(hwdata[B3 + LANE_SEL_LSB +: 3]))
        else $error("channel 3 pattern select not from the top byte");
    gen_run_a: assert property (wr_pat && sel_mac == 2'h0 |=> generator_run[3] == $past(hwdata[B3 + LANE_START]))
        else $error("channel 3 start bit not written");
    sync_len_a: assert property ($rose(checker_sync[3]) |-> checker_sync[3] [*4])
        else $error("checker sync shorter than four cycles");
    sync_drop_a: assert property ($fell(checker_sync[3]) |-> $past(checker_sync[3], 4))
        else $error("checker sync dropped early");
    sync_max_a: assert property (sync_high_count <= 3'(SYNC_PULSE_CYCLES))
        else $error("checker sync longer than four cycles");
    freeze_gate_a: assert property (counter_freeze[3] |-> !counter_enable[3])
        else $error("counters enabled while frozen");
    resume_sync_a: assert property ($rose(counter_enable[3])
        |-> $past(wr_pat && sel_mac == 2'h0 && hwdata[B3 + LANE_SYNC] && !hwdata[B3 + LANE_FREEZE]))
        else $error("counters resumed without a sync");
    clear_pulse_a: assert property (wr_pat && sel_mac == 2'h0 && hwdata[B3 + LANE_CLEAR] |=> counter_clear[3])
        else $error("clear pulse missing");
    clear_source_a: assert property (counter_clear[3]
        |-> $past(wr_pat && sel_mac == 2'h0 && hwdata[B3 + LANE_CLEAR]))
        else $error("clear pulse without a clear write");
    read_wait_a: assert property (rd_q |-> !hreadyout ##1 hreadyout)
        else $error("read data phase wait state wrong");
    write_nowait_a: assert property (wr_q |-> hreadyout)
        else $error("write data phase stalled");

    cover_clk_write: cover property (wr_clk ##1 clock_select[1:0] == CLK_REF1);
    cover_sync: cover property ($rose(checker_sync[3]));
    cover_pat_read: cover property (rd_q && hit_pat);
    cover_resume: cover property ($fell(counter_freeze[3]) ##[1:20] counter_enable[3]);
    cover_clear: cover property (counter_clear[3]);
endmodule // pcr_port_clock_reset_prbs_ctrl

// *** hdl/pcr_pkg.sv ***
/*
 * Shared constants and types for the port clock / reset / test-pattern
 * control block: register offsets, field positions, reset values and
 * the encodings of the clock-source and pattern-select fields.
 * Assumes a 32-bit register bus with one aligned word per register.
 */
package pcr_pkg;
    localparam int NUM_MACS = 4;
    localparam int LANES = 4;
    localparam int NUM_CH = 16;
    localparam int LANE_W = 8;

    // first instance of each register; the others sit 0x200 apart
    localparam logic [31:0] OFF_CLK_SEL = 32'h0001_30C4;
    localparam logic [31:0] OFF_PAT_CTRL = 32'h0001_30C8;
    localparam logic [31:0] MAC_STRIDE_BITS = 32'h0000_0600;
    localparam int MAC_SEL_LSB = 9;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // printed bit n is hardware bit 31-n (printed bit 0 is the msb)
    localparam int BIT_ODD_RST = 5;
    localparam int BIT_EVEN_RST = 4;
    localparam int BIT_ODD_PD = 3;
    localparam int BIT_PAIR_PD = 2;
    localparam int CLK_SEL_LSB = 0;
    localparam int CLK_USED_W = 6;

    // one byte lane per channel, channel 3 in the top byte
    localparam int LANE_SEL_LSB = 4;
    localparam int LANE_START = 3;
    localparam int LANE_SYNC = 2;
    localparam int LANE_FREEZE = 1;
    localparam int LANE_CLEAR = 0;

    // reset values (straps replace the sampled fields after release)
    localparam logic BIT_RESET = 1'b0;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    localparam logic [2:0] PAT_SEL_RESET = 3'h0;
    localparam logic [31:0] PAT_CTRL_RESET = 32'h0000_0000;

    // checker sync pulse length in clock cycles
    localparam int SYNC_PULSE_CYCLES = 4;

    typedef enum logic [1:0] {
        CLK_REF2_DIV2 = 2'b00,
        CLK_REF2 = 2'b01,
        CLK_REF1 = 2'b10,
        CLK_RSVD = 2'b11
    } pcr_clk_src_t;

    typedef enum logic [2:0] {
        PAT_NONE = 3'b000,
        PAT_PRBS = 3'b001,
        PAT_LINE_LOOP = 3'b010,
        PAT_FIXED = 3'b100
    } pcr_pattern_t;
endpackage

// *** hdl/pcr_pulse_stretch.sv ***
/*
 * Stretches a one-cycle start into a fixed-length high level.
 * Assumes start is synchronous to hclk; a new start restarts the pulse.
 */
`timescale 1ns/1ps
module pcr_pulse_stretch
    import pcr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    output logic active
);
    logic [2:0] left;

    // count down the remaining high cycles after the start edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left <= 3'h0;
            active <= 1'b0;
        end else if (start) begin
            left <= 3'(SYNC_PULSE_CYCLES - 1);
            active <= 1'b1;
        end else if (left != 3'h0) begin
            left <= left - 3'h1;
        end else begin
            active <= 1'b0;
        end
    end
endmodule // pcr_pulse_stretch

// *** hdl/pcr_ahb_front.sv ***
/*
 * AHB-Lite slave front end: captures the address phase and marks the
 * data phase. Writes take no wait state, reads take one.
 * Assumes it is the only slave, so hready is its own hreadyout.
 */
`timescale 1ns/1ps
module pcr_ahb_front
    import pcr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic hwrite,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic wr_q,
    output logic rd_q,
    output logic [31:0] addr_q
);
    logic take;

    // only whole-word transfers act; others complete with no effect
    assign take = hsel && htrans[1] && (hsize == 3'h2);

    // read data phase gets one wait cycle so a write just before lands first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hreadyout <= 1'b1;
            addr_q <= 32'h0000_0000;
        end else if (rd_q) begin
            rd_q <= 1'b0;
            hreadyout <= 1'b1;
        end else if (hready) begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            hreadyout <= !(take && !hwrite);
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // responses are always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end
endmodule // pcr_ahb_front

// *** test/test_port_clock_reset_prbs_ctrl.sv ***
/*
 * Self-checking bench for the port clock / reset / test-pattern control block.
 * Assumes the block is the only AHB-Lite slave, so hready is looped back from hreadyout.
 */
`timescale 1ns/1ps
module test_port_clock_reset_prbs_ctrl
    import pcr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    logic hreadyout, hresp;
    logic [7:0] speed_strap_pin, port_power_down_pin, xcvr_power_down, clock_select;
    logic [3:0] odd_port_soft_reset, even_port_transceiver_soft_reset;
    logic [3:0] odd_port_powered_down, even_port_powered_down;
    logic [47:0] tx_pattern_select;
    logic [15:0] generator_run, checker_sync, counter_freeze, counter_clear, counter_enable;
    int mismatches = 0;
    int checks_done = 0;

    // single slave: its hreadyout is the bus hready
    assign hready = hreadyout;

    pcr_port_clock_reset_prbs_ctrl dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hsize(hsize), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .speed_strap_pin(speed_strap_pin), .port_power_down_pin(port_power_down_pin),
        .xcvr_power_down(xcvr_power_down), .clock_select(clock_select),
        .odd_port_soft_reset(odd_port_soft_reset),
        .even_port_transceiver_soft_reset(even_port_transceiver_soft_reset),
        .odd_port_powered_down(odd_port_powered_down), .even_port_powered_down(even_port_powered_down),
        .tx_pattern_select(tx_pattern_select), .generator_run(generator_run),
        .checker_sync(checker_sync), .counter_freeze(counter_freeze),
        .counter_clear(counter_clear), .counter_enable(counter_enable)
    );

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic give_verdict;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // case inequality so an unknown never counts as a match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // wait for hready at a rising edge; only the watchdog ends a hung wait
    task automatic wait_ready;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
    endtask

    task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr_en;
        hsize <= 3'h2;
        wait_ready;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready;
        q = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    // powered-down outputs trail their sources by one extra flop
    task automatic settle;
        repeat (2) @(posedge hclk);
    endtask

    function automatic logic [31:0] mac_addr(input int m, input logic [31:0] base);
        return base + 32'(m) * 32'h200;
    endfunction

    // v is the expected low six bits of the clock-select word of MAC m
    task automatic chk_mac(input int m, input logic [5:0] v);
        logic [31:0] q;
        chk(32'(odd_port_soft_reset[m]), 32'(v[5]));
        chk(32'(even_port_transceiver_soft_reset[m]), 32'(v[4]));
        chk(32'(clock_select[2*m+:2]), 32'(v[1:0]));
        chk(32'(odd_port_powered_down[m]), 32'(v[3] | v[2] | xcvr_power_down[2*m+1]));
        chk(32'(even_port_powered_down[m]), 32'(v[2] | xcvr_power_down[2*m]));
        rd(mac_addr(m, OFF_CLK_SEL), q);
        chk(q, {26'h0, v});
    endtask

    // reset with given straps, then see them captured in every MAC
    task automatic strap_load(input logic [7:0] spd, input logic [7:0] ppd);
        logic [31:0] q;
        speed_strap_pin <= spd;
        port_power_down_pin <= ppd;
        xcvr_power_down <= 8'h00;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        for (int m = 0; m < 4; m++) begin
            chk_mac(m, {2'b00, ppd[2*m+1], ppd[2*m], spd[2*m+:2]});
            rd(mac_addr(m, OFF_PAT_CTRL), q);
            chk(q, PAT_CTRL_RESET);
        end
    endtask

    // writes across MACs one idle cycle apart, reserved bits set, then transceiver power-down ORed in
    task automatic clk_sel_writes;
        logic [5:0] v[4];
        v = '{6'h2D, 6'h12, 6'h33, 6'h0A};
        for (int m = 0; m < 4; m++) begin
            wr(mac_addr(m, OFF_CLK_SEL), 32'hFFFF_FFC0 | 32'(v[m]));
        end
        settle;
        for (int m = 0; m < 4; m++) begin
            chk_mac(m, v[m]);
        end
        xcvr_power_down <= 8'h5A;
        settle;
        for (int m = 0; m < 4; m++) begin
            chk_mac(m, v[m]);
        end
        for (int m = 0; m < 4; m++) begin
            wr(mac_addr(m, OFF_CLK_SEL), 32'h0);
        end
        xcvr_power_down <= 8'hA5;
        settle;
        for (int m = 0; m < 4; m++) begin
            chk_mac(m, 6'h00);
        end
    endtask

    // neighbouring register and a fifth MAC slot are outside the map
    task automatic unmapped;
        logic [31:0] q;
        wr(OFF_CLK_SEL - 32'h4, 32'hFFFF_FFFF);
        rd(OFF_CLK_SEL - 32'h4, q);
        chk(q, READ_UNMAPPED);
        rd(mac_addr(4, OFF_CLK_SEL), q);
        chk(q, READ_UNMAPPED);
        rd(mac_addr(0, OFF_CLK_SEL), q);
        chk(q, 32'h0);
    endtask

    // every pattern code, lanes differ so lane order shows
    task automatic pattern_codes;
        logic [31:0] d, q;
        logic [7:0] b;
        int m, i;
        for (int c = 0; c < 8; c++) begin
            m = c % 4;
            d = 32'h0;
            for (int l = 0; l < 4; l++) begin
                d[8*l+:8] = {1'b1, 3'(c + l), 1'(l ^ (c >> 2)), 1'b0, 1'(l >> 1), 1'b0};
            end
            wr(mac_addr(m, OFF_PAT_CTRL), d);
            settle;
            for (int l = 0; l < 4; l++) begin
                i = 4 * m + l;
                b = d[8*l+:8];
                chk(32'(tx_pattern_select[3*i+:3]), 32'(b[6:4]));
                chk(32'(generator_run[i]), 32'(b[3]));
                chk(32'(counter_freeze[i]), 32'(b[1]));
            end
            rd(mac_addr(m, OFF_PAT_CTRL), q);
            chk(q, d & 32'h7A7A_7A7A);
        end
    endtask

    // channel 3 of MAC 0, the channel the design's assertions watch
    task automatic sync_clear;
        int ns, nc;
        logic [31:0] q;
        wr(mac_addr(0, OFF_PAT_CTRL), 32'h0600_0000);
        repeat (6) @(posedge hclk);
        chk(32'(counter_enable[3]), 32'h0);
        wr(mac_addr(0, OFF_PAT_CTRL), 32'h0500_0000);
        ns = 0;
        nc = 0;
        repeat (8) begin
            @(posedge hclk);
            ns += int'(checker_sync[3] === 1'b1);
            nc += int'(counter_clear[3] === 1'b1);
        end
        chk(32'(ns), 32'(SYNC_PULSE_CYCLES));
        chk(32'(nc), 32'h1);
        chk(32'(counter_enable[3]), 32'h1);
        rd(mac_addr(0, OFF_PAT_CTRL), q);
        chk(q, 32'h0);
        wr(mac_addr(0, OFF_PAT_CTRL), 32'h0200_0000);
        settle;
        chk(32'(counter_freeze[3]), 32'h1);
        chk(32'(counter_enable[3]), 32'h0);
    endtask

    // main sequence; the second strap load is a reset in mid-run
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwrite = 1'b0;
        hwdata = 32'h0;
        speed_strap_pin = 8'h00;
        port_power_down_pin = 8'h00;
        xcvr_power_down = 8'h00;
        strap_load(8'hB4, 8'h96);
        clk_sel_writes;
        unmapped;
        pattern_codes;
        sync_clear;
        strap_load(8'h4B, 8'h69);
        give_verdict;
    end

    // whole run is well under 2000 cycles; this cuts a hung handshake
    initial begin
        #100000;
        mismatches++;
        give_verdict;
    end
endmodule // test_port_clock_reset_prbs_ctrl
